// File: hw/dio_pkg.sv
// Function
// R1: drive select is active when low
// R2: no lock straps: solenoid follows drive select
// R3: unlatched lock: solenoid follows in-use low
// R4: latched lock: set by in-use with select
// R5: lever open sets flag; select trailing edge clears
// R6: disk-change low while selected and flag set
// R7: two-sided low while selected and second hole
// R8: write-inhibit strap blocks gate when protected
// R9: write-allow strap passes gate, still reports protect
// R10: host strap: current follows host switch line
// R11: auto strap: drive switches current itself
// R12: reduced current from track 43 upward
// R13: diagnostic strap sampled at power-up
// R14: test number from four straps, msb first
// R15: diagnostic mode held until power removed
// R16: test 0 seeks track 0, motor on
// R17: test 1 seeks track 1, motor on
// R18: test 2 seeks 0 then 38, motor on
// R19: test 3 seeks 76 then 38, motor on
// R20: test 4 seeks track 76, motor on
// R21: test 5 seeks track 75, motor on
// R22: test 6 toggles indicator per side-zero index
// R23: test 7 toggles indicator per side-one index
// R24: other tests idle, indicator off
`default_nettype none
package dio_pkg;
    localparam int TRACK_W = 7;
    localparam int REG_AW = 4;
    localparam int REG_DW = 16;
    // register offsets
    localparam logic [REG_AW-1:0] OFS_CTRL = 4'h0;
    localparam logic [REG_AW-1:0] OFS_STATUS = 4'h4;
    localparam logic [REG_AW-1:0] OFS_TRACK = 4'h8;
    // control fields
    localparam int CTRL_RESTART = 0;
    // status fields
    localparam int ST_CHANGED = 0;
    localparam int ST_LATCHED = 1;
    localparam int ST_DIAG = 2;
    localparam int ST_LOWCUR = 3;
    localparam int ST_SEEKING = 4;
    localparam int ST_TEST_LSB = 8;
    // track figures
    localparam logic [TRACK_W-1:0] TRK_SWITCH = 7'h2B;
    localparam logic [TRACK_W-1:0] TRK_0 = 7'h00;
    localparam logic [TRACK_W-1:0] TRK_1 = 7'h01;
    localparam logic [TRACK_W-1:0] TRK_38 = 7'h26;
    localparam logic [TRACK_W-1:0] TRK_75 = 7'h4B;
    localparam logic [TRACK_W-1:0] TRK_76 = 7'h4C;
    // test codes
    localparam logic [3:0] TEST_0 = 4'h0;
    localparam logic [3:0] TEST_1 = 4'h1;
    localparam logic [3:0] TEST_2 = 4'h2;
    localparam logic [3:0] TEST_3 = 4'h3;
    localparam logic [3:0] TEST_4 = 4'h4;
    localparam logic [3:0] TEST_5 = 4'h5;
    localparam logic [3:0] TEST_6 = 4'h6;
    localparam logic [3:0] TEST_7 = 4'h7;
    // cycles after reset release before straps are trusted
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    typedef enum logic [2:0] {
        DIO_WAIT, DIO_SEEK_A, DIO_WAIT_A, DIO_SEEK_B, DIO_WAIT_B, DIO_HOLD
    } dio_diag_t;
endpackage
`default_nettype wire

// File: hw/dio_top.sv
`default_nettype none
module dio_top #(
    parameter int TRACK_W = dio_pkg::TRACK_W
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // host interface lines, all active low
    input wire logic i_drive_sel_n,
    input wire logic i_in_use_n,
    input wire logic i_write_gate_n,
    input wire logic i_wcur_switch_n,
    output logic o_disk_change_n,
    output logic o_two_sided_n,
    output logic o_write_protect_n,
    // drive sensors
    input wire logic i_lever_open,
    input wire logic i_second_hole,
    input wire logic i_protect_sense,
    input wire logic i_index_side0,
    input wire logic i_index_side1,
    // option straps, high when fitted
    input wire logic i_lock_enable_strap,
    input wire logic i_solenoid_strap,
    input wire logic i_latched_lock_strap,
    input wire logic i_unlatched_lock_strap,
    input wire logic i_media_swap_strap,
    input wire logic i_dual_side_strap,
    input wire logic i_write_inhibit_strap,
    input wire logic i_write_allow_strap,
    input wire logic i_host_current_strap,
    input wire logic i_auto_current_strap,
    input wire logic i_diagnostic_strap,
    input wire logic i_test_bit0_strap,
    input wire logic i_test_bit1_strap,
    input wire logic i_test_bit2_strap,
    // drive mechanics
    input wire logic [TRACK_W-1:0] i_head_track,
    input wire logic i_seek_done,
    output logic o_solenoid,
    output logic o_write_enable,
    output logic o_low_current,
    output logic o_motor_on,
    output logic o_led,
    output logic o_seek_req,
    output logic [TRACK_W-1:0] o_seek_track,
    // register port
    input wire logic [dio_pkg::REG_AW-1:0] i_reg_addr,
    input wire logic [dio_pkg::REG_DW-1:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [dio_pkg::REG_DW-1:0] o_reg_rdata
);
    import dio_pkg::*;

    if (TRACK_W < 7 || TRACK_W > 12) begin : g_bad_width
        $error("TRACK_W must hold track 76 and fit the track register");
    end

    function automatic logic rise(input logic cur, input logic prev);
        rise = cur & ~prev;
    endfunction

    function automatic logic [TRACK_W-1:0] trk(input logic [6:0] t);
        trk = TRACK_W'(t);
    endfunction

    // two-stage synchronisers for host, sensor and strap pins, test bits in a separate pair
    localparam int NSYNC = 20;
    logic [NSYNC-1:0] pins;
    logic [NSYNC-1:0] meta_q;
    logic [NSYNC-1:0] sync_q;
    assign pins = {i_drive_sel_n, i_in_use_n, i_write_gate_n, i_wcur_switch_n,
                   i_lever_open, i_second_hole, i_protect_sense, i_index_side0,
                   i_index_side1, i_lock_enable_strap, i_solenoid_strap,
                   i_latched_lock_strap, i_unlatched_lock_strap, i_media_swap_strap,
                   i_dual_side_strap, i_write_inhibit_strap, i_write_allow_strap,
                   i_host_current_strap, i_auto_current_strap, i_diagnostic_strap};

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_q <= 20'hF0000;
            sync_q <= 20'hF0000;
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
        end
    end

    logic [2:0] tbits_meta_q;
    logic [2:0] tbits_q;
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            tbits_meta_q <= 3'h0;
            tbits_q <= 3'h0;
        end else begin
            tbits_meta_q <= {i_test_bit2_strap, i_test_bit1_strap, i_test_bit0_strap};
            tbits_q <= tbits_meta_q;
        end
    end

    logic sel;
    logic in_use;
    logic host_wg;
    logic host_low;
    logic lever_open;
    logic second_hole;
    logic prot;
    logic idx0;
    logic idx1;
    logic s_lock;
    logic s_sol;
    logic s_latch;
    logic s_unlatch;
    logic s_swap;
    logic s_dual;
    logic s_inhibit;
    logic s_allow;
    logic s_host_cur;
    logic s_auto_cur;
    logic s_diag;
    assign sel = ~sync_q[19]; // R1
    assign in_use = ~sync_q[18];
    assign host_wg = ~sync_q[17];
    assign host_low = ~sync_q[16];
    assign lever_open = sync_q[15];
    assign second_hole = sync_q[14];
    assign prot = sync_q[13];
    assign idx0 = sync_q[12];
    assign idx1 = sync_q[11];
    assign s_lock = sync_q[10];
    assign s_sol = sync_q[9];
    assign s_latch = sync_q[8];
    assign s_unlatch = sync_q[7];
    assign s_swap = sync_q[6];
    assign s_dual = sync_q[5];
    assign s_inhibit = sync_q[4];
    assign s_allow = sync_q[3];
    assign s_host_cur = sync_q[2];
    assign s_auto_cur = sync_q[1];
    assign s_diag = sync_q[0];

    // previous values for edge detection
    logic sel_prev_q;
    logic lever_prev_q;
    logic idx0_prev_q;
    logic idx1_prev_q;
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            sel_prev_q <= 1'b0;
            lever_prev_q <= 1'b0;
            idx0_prev_q <= 1'b0;
            idx1_prev_q <= 1'b0;
        end else begin
            sel_prev_q <= sel;
            lever_prev_q <= lever_open;
            idx0_prev_q <= idx0;
            idx1_prev_q <= idx1;
        end
    end

    logic sel_lead;
    logic sel_trail;
    assign sel_lead = rise(sel, sel_prev_q);
    assign sel_trail = rise(sel_prev_q, sel);

    // power-up strap capture; mode only leaves with reset
    logic [1:0] settle_q;
    logic ready_q;
    logic diag_q;
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            settle_q <= 2'h0;
            ready_q <= 1'b0;
            diag_q <= 1'b0;
        end else if (!ready_q) begin
            if (settle_q == STRAP_SETTLE) begin
                ready_q <= 1'b1;
                diag_q <= s_diag; // R13 R15
            end else begin
                settle_q <= settle_q + 2'h1;
            end
        end
    end

    logic normal;
    assign normal = ready_q & ~diag_q;

    // lever lock latch
    logic latched_q;
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            latched_q <= 1'b0;
        end else if (!(s_lock && s_sol && s_latch) || !normal) begin
            latched_q <= 1'b0;
        end else if (in_use && sel) begin
            latched_q <= 1'b1; // R4
        end else if (sel_lead && !in_use) begin
            latched_q <= 1'b0; // R4
        end
    end

    logic sol_d;
    always_comb begin
        sol_d = 1'b0;
        if (normal) begin
            if (!s_lock && !s_sol && !s_latch && !s_unlatch) begin
                sol_d = sel; // R2
            end else if (s_lock && s_sol && s_unlatch && !s_latch) begin
                sol_d = in_use; // R3
            end else if (s_lock && s_sol && s_latch && !s_unlatch) begin
                sol_d = latched_q; // R4
            end
        end
    end

    // disk-changed flag, opening edge wins over the clear
    logic changed_q;
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            changed_q <= 1'b0;
        end else if (rise(lever_open, lever_prev_q)) begin
            changed_q <= 1'b1; // R5
        end else if (sel_trail) begin
            changed_q <= 1'b0; // R5
        end
    end

    logic low_cur_d;
    always_comb begin
        low_cur_d = 1'b0;
        if (s_host_cur) begin
            low_cur_d = host_low; // R10
        end else if (s_auto_cur) begin
            low_cur_d = (i_head_track >= trk(TRK_SWITCH)); // R11 R12
        end
    end

    // interface outputs
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_solenoid <= 1'b0;
            o_disk_change_n <= 1'b1;
            o_two_sided_n <= 1'b1;
            o_write_protect_n <= 1'b1;
            o_write_enable <= 1'b0;
            o_low_current <= 1'b0;
        end else begin
            o_solenoid <= sol_d;
            o_disk_change_n <= ~(normal & s_swap & sel & changed_q); // R6
            o_two_sided_n <= ~(normal & s_dual & sel & second_hole); // R7
            o_write_protect_n <= ~(normal & sel & prot); // R9
            o_write_enable <= normal & sel & host_wg &
                              (s_allow | ~(s_inhibit & prot)); // R8 R9
            o_low_current <= normal & low_cur_d;
        end
    end

    // diagnostic sequencer
    logic [3:0] test_num;
    assign test_num = {s_sol, tbits_q}; // R14

    logic restart_q;
    logic [3:0] test_q;
    dio_diag_t state_q;
    logic [TRACK_W-1:0] first_trk;
    logic [TRACK_W-1:0] second_trk;
    logic two_step;
    logic seeks;

    always_comb begin
        first_trk = trk(TRK_0);
        second_trk = trk(TRK_0);
        two_step = 1'b0;
        seeks = 1'b1;
        unique case (test_q)
            TEST_0: first_trk = trk(TRK_0); // R16
            TEST_1: first_trk = trk(TRK_1); // R17
            TEST_2: begin // R18
                first_trk = trk(TRK_0);
                second_trk = trk(TRK_38);
                two_step = 1'b1;
            end
            TEST_3: begin // R19
                first_trk = trk(TRK_76);
                second_trk = trk(TRK_38);
                two_step = 1'b1;
            end
            TEST_4: first_trk = trk(TRK_76); // R20
            TEST_5: first_trk = trk(TRK_75); // R21
            default: seeks = 1'b0; // R24
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= DIO_WAIT;
            test_q <= 4'h0;
            o_seek_req <= 1'b0;
            o_seek_track <= '0;
        end else begin
            o_seek_req <= 1'b0;
            if (!ready_q || !diag_q) begin
                state_q <= DIO_WAIT;
            end else if (test_num != test_q || restart_q) begin
                test_q <= test_num;
                state_q <= DIO_WAIT;
            end else begin
                unique case (state_q)
                    DIO_WAIT: state_q <= seeks ? DIO_SEEK_A : DIO_HOLD;
                    DIO_SEEK_A: begin
                        o_seek_req <= 1'b1;
                        o_seek_track <= first_trk;
                        state_q <= DIO_WAIT_A;
                    end
                    DIO_WAIT_A: begin
                        if (i_seek_done) begin
                            state_q <= two_step ? DIO_SEEK_B : DIO_HOLD;
                        end
                    end
                    DIO_SEEK_B: begin
                        o_seek_req <= 1'b1;
                        o_seek_track <= second_trk;
                        state_q <= DIO_WAIT_B;
                    end
                    DIO_WAIT_B: begin
                        if (i_seek_done) begin
                            state_q <= DIO_HOLD;
                        end
                    end
                    DIO_HOLD: state_q <= DIO_HOLD;
                endcase
            end
        end
    end

    // spindle and indicator
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_motor_on <= 1'b0;
            o_led <= 1'b0;
        end else if (!ready_q || !diag_q || test_num != test_q) begin
            o_motor_on <= 1'b0;
            o_led <= 1'b0;
        end else begin
            o_motor_on <= (test_q <= TEST_7);
            if (test_q == TEST_6) begin
                o_led <= o_led ^ rise(idx0, idx0_prev_q); // R22
            end else if (test_q == TEST_7) begin
                o_led <= o_led ^ rise(idx1, idx1_prev_q); // R23
            end else begin
                o_led <= 1'b0; // R24
            end
        end
    end

    // register port
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            restart_q <= 1'b0;
        end else begin
            restart_q <= i_reg_wr && i_reg_addr == OFS_CTRL && i_reg_wdata[CTRL_RESTART];
        end
    end

    logic [REG_DW-1:0] status;
    always_comb begin
        status = '0;
        status[ST_CHANGED] = changed_q;
        status[ST_LATCHED] = latched_q;
        status[ST_DIAG] = diag_q;
        status[ST_LOWCUR] = o_low_current;
        status[ST_SEEKING] = (state_q == DIO_WAIT_A) || (state_q == DIO_WAIT_B);
        status[ST_TEST_LSB +: 4] = test_q;
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_reg_rdata <= '0;
        end else if (i_reg_rd) begin
            unique case (i_reg_addr)
                OFS_STATUS: o_reg_rdata <= status;
                OFS_TRACK: o_reg_rdata <= REG_DW'(i_head_track);
                default: o_reg_rdata <= '0;
            endcase
        end else begin
            o_reg_rdata <= '0;
        end
    end
endmodule
`default_nettype wire

// File: dv/dio_chk_assertions.sv
`default_nettype none
module dio_chk
    import dio_pkg::*;
#(
    parameter int TRACK_W = 7
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // host lines and sensors
    input wire logic i_drive_sel_n,
    input wire logic i_write_gate_n,
    input wire logic i_wcur_switch_n,
    input wire logic i_protect_sense,
    input wire logic i_reg_wr,
    input wire logic [TRACK_W-1:0] i_head_track,
    // straps
    input wire logic i_media_swap_strap,
    input wire logic i_write_inhibit_strap,
    input wire logic i_write_allow_strap,
    input wire logic i_host_current_strap,
    input wire logic i_auto_current_strap,
    input wire logic i_diagnostic_strap,
    input wire logic i_solenoid_strap,
    input wire logic i_test_bit0_strap,
    input wire logic i_test_bit1_strap,
    input wire logic i_test_bit2_strap,
    // outputs watched
    input wire logic o_disk_change_n,
    input wire logic o_solenoid,
    input wire logic o_write_enable,
    input wire logic o_low_current,
    input wire logic o_motor_on,
    input wire logic o_led
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q;
    logic ok;
    logic dg;
    logic [3:0] tst;
    assign ok = cnt_q >= 4'h8;
    assign dg = ok && i_diagnostic_strap;
    assign tst = {i_solenoid_strap, i_test_bit2_strap, i_test_bit1_strap, i_test_bit0_strap};
    // edges since reset release, saturating
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= 4'h0;
        end else if (cnt_q != 4'hF) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    property p_chg;
        !o_disk_change_n |-> $past(!i_drive_sel_n, 3) && i_media_swap_strap;
    endproperty
    a_chg: assert property (p_chg) else $error("change low unselected");
    property p_we;
        o_write_enable |-> $past(!i_drive_sel_n && !i_write_gate_n, 3);
    endproperty
    a_we: assert property (p_we) else $error("write enable unselected");
    property p_inh;
        o_write_enable && i_write_inhibit_strap && !i_write_allow_strap
            |-> !$past(i_protect_sense, 3);
    endproperty
    a_inh: assert property (p_inh) else $error("write on protected media");
    property p_cur;
        ok && i_host_current_strap |-> o_low_current == $past(!i_wcur_switch_n, 3);
    endproperty
    a_cur: assert property (p_cur) else $error("host current not followed");
    property p_auto;
        (ok && i_auto_current_strap && !i_host_current_strap && $stable(i_head_track))[*3]
            |-> o_low_current == (i_head_track >= TRK_SWITCH);
    endproperty
    a_auto: assert property (p_auto) else $error("auto current wrong");
    property p_diag;
        dg |-> !o_solenoid && !o_write_enable && o_disk_change_n;
    endproperty
    a_diag: assert property (p_diag) else $error("interface active in test mode");
    property p_mot;
        dg && tst < 4'h8 && !$past(i_reg_wr) && !$past(i_reg_wr, 2) |-> o_motor_on;
    endproperty
    a_mot: assert property (p_mot) else $error("motor off in test");
    property p_idle;
        dg && tst >= 4'h8 |-> !o_motor_on && !o_led;
    endproperty
    a_idle: assert property (p_idle) else $error("unused test not idle");
    cover property (!o_disk_change_n);
    cover property ($changed(o_led));
    cover property ($rose(o_low_current));
endmodule
bind dio_top dio_chk #(.TRACK_W(TRACK_W)) i_chk (.*);
`default_nettype wire

// File: dv/dio_carriage.sv
`default_nettype none
module dio_carriage #(
    parameter int TRACK_W = 7
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // seek port
    input wire logic i_seek_req,
    input wire logic [TRACK_W-1:0] i_seek_track,
    output logic o_seek_done,
    output logic [TRACK_W-1:0] o_head_track,
    // bench preload of head position
    input wire logic i_load,
    input wire logic [TRACK_W-1:0] i_load_track
);
    timeunit 1ns;
    timeprecision 1ps;
    int left_q;
    logic [TRACK_W-1:0] tgt_q;
    // seeks take a random 1 to 12 cycles
    always @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_seek_done <= 1'b0;
            o_head_track <= 7'h14;
            left_q <= 0;
        end else begin
            o_seek_done <= 1'b0;
            if (i_load) begin
                o_head_track <= i_load_track;
            end
            if (i_seek_req) begin
                tgt_q <= i_seek_track;
                left_q <= $urandom_range(12, 1);
            end else if (left_q == 1) begin
                o_head_track <= tgt_q;
                o_seek_done <= 1'b1;
                left_q <= 0;
            end else if (left_q > 1) begin
                left_q <= left_q - 1;
            end
        end
    end
endmodule
`default_nettype wire

// File: dv/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dio_pkg::*;
    localparam logic [13:0] LE = 14'h0001, SO = 14'h0002, LA = 14'h0004, UN = 14'h0008;
    localparam logic [13:0] SW = 14'h0010, DU = 14'h0020, IN = 14'h0040, AL = 14'h0080;
    localparam logic [13:0] HO = 14'h0100, AU = 14'h0200, DG = 14'h0400;
    logic clk = 1'b0, rst_n = 1'b0, ld = 1'b0, wr = 1'b0, rd = 1'b0, rp = 1'b0;
    logic sel_n, use_n, gate_n, wcur_n, lever, hole, prot, ix0, ix1;
    logic dc_n, ts_n, wp_n, sol, we, low, mot, led, done, sreq;
    logic [13:0] s;
    logic [REG_AW-1:0] addr = 4'h0;
    logic [REG_DW-1:0] wd = 16'h0000, rdata;
    logic [TRACK_W-1:0] trk, trk_w, skt, ld_trk = 7'h00;
    logic [15:0] qo[$];
    logic [31:0] qr[$];
    logic [TRACK_W-1:0] qt[$];
    int bad_count = 0, n_tests = 0;
    event ev_o;
    always #5 clk = ~clk;
    dio_top i_dut (
        .i_mclk(clk), .i_nrst(rst_n), .i_drive_sel_n(sel_n), .i_in_use_n(use_n),
        .i_write_gate_n(gate_n), .i_wcur_switch_n(wcur_n), .o_disk_change_n(dc_n),
        .o_two_sided_n(ts_n), .o_write_protect_n(wp_n), .i_lever_open(lever),
        .i_second_hole(hole), .i_protect_sense(prot), .i_index_side0(ix0),
        .i_index_side1(ix1), .i_lock_enable_strap(s[0]), .i_solenoid_strap(s[1]),
        .i_latched_lock_strap(s[2]), .i_unlatched_lock_strap(s[3]),
        .i_media_swap_strap(s[4]), .i_dual_side_strap(s[5]), .i_write_inhibit_strap(s[6]),
        .i_write_allow_strap(s[7]), .i_host_current_strap(s[8]),
        .i_auto_current_strap(s[9]), .i_diagnostic_strap(s[10]), .i_test_bit0_strap(s[11]),
        .i_test_bit1_strap(s[12]), .i_test_bit2_strap(s[13]), .i_head_track(trk_w),
        .i_seek_done(done), .o_solenoid(sol), .o_write_enable(we), .o_low_current(low),
        .o_motor_on(mot), .o_led(led), .o_seek_req(sreq), .o_seek_track(skt),
        .i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata)
    );
    dio_carriage i_far (
        .i_mclk(clk), .i_nrst(rst_n), .i_seek_req(sreq), .i_seek_track(skt),
        .o_seek_done(done), .o_head_track(trk_w), .i_load(ld), .i_load_track(ld_trk)
    );
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic fail(input string m);
        $display("unexpected %0t %s", $time, m);
        bad_count++;
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // power cycle with a new strap set, host lines idle
    task automatic cfg(input logic [13:0] v);
        rst_n <= 1'b0;
        s <= v;
        {sel_n, use_n, gate_n, wcur_n} <= 4'hF;
        {lever, hole, prot, ix0, ix1} <= 5'h00;
        cyc(3);
        rst_n <= 1'b1;
        cyc(8);
    endtask
    task automatic chk(input logic [7:0] e, input logic [7:0] m);
        cyc(5);
        @(negedge clk);
        qo.push_back({m, e});
        ->ev_o;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [REG_AW-1:0] a, input logic [15:0] e, input logic [15:0] m);
        addr <= a;
        rd <= 1'b1;
        qr.push_back({m, e});
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask
    always @(ev_o) begin
        logic [15:0] x;
        x = qo.pop_front();
        n_tests++;
        if (({dc_n, ts_n, wp_n, sol, we, low, mot, led} & x[15:8]) !== (x[7:0] & x[15:8])) begin
            fail("outputs");
        end
    end
    always @(posedge clk) rp <= rd;
    always @(negedge clk) begin
        logic [31:0] x;
        if (rp) begin
            x = qr.pop_front();
            n_tests++;
            if ((rdata & x[31:16]) !== (x[15:0] & x[31:16])) begin
                fail("read data");
            end
        end
    end
    always @(posedge clk) begin
        if (sreq === 1'b1) begin
            n_tests++;
            if (qt.size() == 0 || skt !== qt.pop_front()) begin
                fail("seek target");
            end
        end
    end
    initial begin
        void'($urandom(32'h9B0AEB0E));
        cfg(14'h0000);
        sel_n <= 1'b0;
        chk(8'hF0, 8'hFE);
        sel_n <= 1'b1;
        chk(8'hE0, 8'hFE);
        cfg(LE | SO | UN);
        use_n <= 1'b0;
        chk(8'hF0, 8'hFE);
        cfg(LE | SO | LA);
        {use_n, sel_n} <= 2'b00;
        chk(8'hF0, 8'hFE);
        {use_n, sel_n} <= 2'b11;
        chk(8'hF0, 8'hFE);
        sel_n <= 1'b0;
        chk(8'hE0, 8'hFE);
        $display("lock tests done");
        cfg(SW | DU);
        {lever, hole} <= 2'b11;
        cyc(3);
        {lever, sel_n} <= 2'b00;
        chk(8'h30, 8'hFE);
        rdc(OFS_STATUS, 16'h0001, 16'h0001);
        sel_n <= 1'b1;
        chk(8'hE0, 8'hFE);
        {hole, sel_n} <= 2'b00;
        chk(8'hF0, 8'hFE);
        $display("status line tests done");
        cfg(IN);
        {prot, sel_n, gate_n} <= 3'b100;
        chk(8'hD0, 8'hFE);
        prot <= 1'b0;
        chk(8'hF8, 8'hFE);
        cfg(AL);
        {prot, sel_n, gate_n} <= 3'b100;
        chk(8'hD8, 8'hFE);
        cfg(HO);
        wcur_n <= 1'b0;
        chk(8'hE4, 8'hFE);
        wcur_n <= 1'b1;
        chk(8'hE0, 8'hFE);
        cfg(AU);
        for (int i = 0; i < 12; i++) begin
            trk = (i < 2) ? TRK_SWITCH - 7'h01 + 7'(i) : 7'($urandom_range(int'(TRK_76), 0));
            ld_trk <= trk;
            ld <= 1'b1;
            @(posedge clk);
            ld <= 1'b0;
            chk((trk >= TRK_SWITCH) ? 8'hE4 : 8'hE0, 8'hFE);
        end
        rdc(OFS_TRACK, 16'(trk), 16'hFFFF);
        rdc(4'hC, 16'h0000, 16'hFFFF);
        $display("write tests done");
        for (int t = 0; t < 6; t++) begin
            case (t)
                0: qt = '{TRK_0};
                1: qt = '{TRK_1};
                2: qt = '{TRK_0, TRK_38};
                3: qt = '{TRK_76, TRK_38};
                4: qt = '{TRK_76};
                default: qt = '{TRK_75};
            endcase
            cfg(DG | (14'(t) << 11));
            {use_n, sel_n} <= 2'b00;
            cyc(60);
            chk(8'hE2, 8'hFA);
            rdc(OFS_STATUS, 16'h0004 | (16'(t) << 8), 16'h0F04);
            if (qt.size() != 0) fail("seek missing");
        end
        qt.push_back(TRK_75);
        addr <= OFS_CTRL;
        wd <= 16'h0001;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        cyc(40);
        if (qt.size() != 0) fail("restart seek missing");
        s <= s & ~DG;
        chk(8'hE2, 8'hFA);
        for (int k = 0; k < 2; k++) begin
            cfg(DG | 14'h3000 | (k == 1 ? 14'h0800 : 14'h0000));
            for (int i = 0; i < 3; i++) begin
                {ix1, ix0} <= ((i == 1) ^ (k == 1)) ? 2'b10 : 2'b01;
                cyc(3);
                {ix1, ix0} <= 2'b00;
                chk({7'h71, i != 2}, 8'hFB);
            end
        end
        cfg(DG | SO | 14'h0800);
        ix0 <= 1'b1;
        cyc(3);
        ix0 <= 1'b0;
        chk(8'hE0, 8'hFB);
        $display("diagnostic tests done");
        report_and_stop();
    end
    initial begin
        cyc(20000);
        fail("timeout");
        report_and_stop();
    end
endmodule
`default_nettype wire
